//--- design/kric_pkg.sv
// constants shared by the knob, release and iris control logic
//**********************************************************************
// Function
// - send only knob change per sampling interval
// - reconnection sends relative data, no jump
// - release switch held suppresses covered knobs
// - release let go takes new reference
// - release covers iris only in relative mode
// - short press latches the release state
// - release lamp lit while latch active
// - second press clears latch
// - latch cleared at reset and reassignment
// - absolute iris: lamp dark, absolute value
// - relative iris: lamp lit, relative data
// - iris mode configurable, default by connection
// - full range ignores span knobs
// - limited range: centre and width window
// - relative press: clear file then data
// - full press toggles span, clears file
// - mismatch blinks relative lamp, can disable
// - auto iris allows plus/minus one stop
// - full state kept over enable toggling
// - absolute mode sends knob value on connect
//**********************************************************************
package kric_pkg;
    localparam int          KNOB_W      = 10;   // converter width
    localparam int          DELTA_W     = 11;   // signed change width
    localparam int          N_GEN       = 6;    // gain..gamma knobs
    localparam int          ASSIGN_W    = 8;    // camera assignment
    localparam int unsigned CLK_HZ      = 125_000_000;
    localparam real         LATCH_WIN_S = 0.5;  // short press window
    localparam real         BLINK_HALF_S = 0.25; // lamp blink half period
    // both times round down to whole cycles
    localparam int unsigned LATCH_WIN_CYC =
        int'($floor(LATCH_WIN_S * CLK_HZ));
    localparam int unsigned BLINK_HALF_CYC =
        int'($floor(BLINK_HALF_S * CLK_HZ));
    localparam logic [KNOB_W-1:0] IRIS_MID   = 10'h200; // mid scale
    localparam logic [KNOB_W-1:0] IRIS_MAX   = 10'h3ff; // top of range
    localparam logic [KNOB_W-1:0] IRIS_FSTOP = 10'h080; // one f-stop
    localparam int          SCALE_SH    = 9;    // knob offset scaling
    localparam logic        FULL_RST    = 1'b0; // full switch at reset
    // release switch states, one-hot
    typedef enum logic [4:0] {
        REL_IDLE   = 5'b00001,
        REL_TIMING = 5'b00010,
        REL_HELD   = 5'b00100,
        REL_LOCKED = 5'b01000,
        REL_UNLOCK = 5'b10000
    } kric_rel_state_t;
endpackage

//--- design/kric_knob_delta.sv
// one knob channel: keeps a reference and reports change only
module kric_knob_delta
(
    input  wire logic                          mclk,
    input  wire logic                          reset_n,
    input  wire logic [kric_pkg::KNOB_W-1:0]   pos,      // converted knob
    input  wire logic                          sample,   // interval tick
    input  wire logic                          hold,     // release active
    input  wire logic                          rebase,   // reconnection
    input  wire logic                          zero_ref, // resend whole
    output logic      [kric_pkg::DELTA_W-1:0]  delta
);
    import kric_pkg::*;
    logic [KNOB_W-1:0]  ref_reg;   // position at last conversion
    logic [KNOB_W-1:0]  ref_next;
    logic [DELTA_W-1:0] delta_next;
    wire  [DELTA_W-1:0] diff = {1'b0, pos} - {1'b0, ref_reg};

    //******************************************************************
    // reference tracking
    //******************************************************************
    // held or reconnected: follow the knob silently so nothing jumps
    always_comb
    begin
        ref_next   = ref_reg;
        delta_next = '0;
        if (zero_ref)
        begin
            ref_next = '0;               // next change is the whole value
        end
        else if (hold || rebase)
        begin
            ref_next = pos;
        end
        else if (sample)
        begin
            delta_next = diff;
            ref_next   = pos;
        end
    end

    // delta stands until the next tick; zero when nothing is sent
    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            ref_reg <= '0;
            delta   <= '0;
        end
        else
        begin
            ref_reg <= ref_next;
            if (sample || hold || rebase || zero_ref)
                delta <= delta_next;
        end
    end

    chk_held_no_data: assert property (@(posedge mclk) disable iff (!reset_n)
        hold && !zero_ref |=> delta == '0)
        else $error("knob change sent while release held");
    chk_delta_is_diff: assert property (@(posedge mclk) disable iff (!reset_n)
        sample && !hold && !rebase && !zero_ref
        |=> delta == $past(pos) - $past(ref_reg))
        else $error("knob change not the difference");
endmodule

//--- design/kric_release_ctl.sv
// knob release switch: momentary release, short press lock, lamp
module kric_release_ctl
#(
    parameter int unsigned LATCH_CYC = kric_pkg::LATCH_WIN_CYC
)
(
    input  wire logic mclk,
    input  wire logic reset_n,
    input  wire logic sw,          // release switch, high while pressed
    input  wire logic clear_latch, // camera assignment changed
    output logic      active,      // knobs covered are frozen
    output logic      lamp         // lock indication
);
    import kric_pkg::*;
    localparam int TW = $clog2(LATCH_CYC + 1);
    kric_rel_state_t state_reg, state_next;
    logic [TW-1:0]   timer_reg;    // press duration
    wire             win_over = timer_reg == TW'(LATCH_CYC - 1);

    //******************************************************************
    // state machine
    //******************************************************************
    always_comb
    begin
        state_next = state_reg;
        case (state_reg)
            REL_IDLE:   if (sw) state_next = REL_TIMING;
            REL_TIMING:
                if (!sw) state_next = REL_LOCKED;
                else if (win_over) state_next = REL_HELD;
            REL_HELD:   if (!sw) state_next = REL_IDLE;
            REL_LOCKED:
                if (clear_latch) state_next = REL_IDLE;
                else if (sw) state_next = REL_UNLOCK;
            REL_UNLOCK: if (!sw) state_next = REL_IDLE;
            default:    state_next = REL_IDLE;
        endcase
    end

    // timer only runs while the press is being judged
    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            state_reg <= REL_IDLE;
            timer_reg <= '0;
            lamp      <= 1'b0;
        end
        else
        begin
            state_reg <= state_next;
            timer_reg <= (state_next == REL_TIMING) ? timer_reg + 1'b1 : '0;
            lamp      <= state_next == REL_LOCKED;
        end
    end

    assign active = state_reg != REL_IDLE;

    chk_short_locks: assert property (@(posedge mclk) disable iff (!reset_n)
        state_reg == REL_TIMING && !sw |=> lamp && active)
        else $error("short press did not lock");
    chk_long_free: assert property (@(posedge mclk) disable iff (!reset_n)
        state_reg == REL_HELD && !sw |=> !active ##1 !lamp)
        else $error("long hold left release active");
    chk_reassign_clr: assert property (@(posedge mclk) disable iff (!reset_n)
        clear_latch && state_reg == REL_LOCKED |=> !lamp && !active)
        else $error("lock kept over reassignment");
endmodule

//--- design/kric_panel_ctl.sv
// panel top: knob change data, release handling and iris control
module kric_panel_ctl
#(
    parameter int unsigned LATCH_CYC = kric_pkg::LATCH_WIN_CYC,
    parameter int unsigned BLINK_CYC = kric_pkg::BLINK_HALF_CYC
)
(
    input  wire logic                                  mclk,
    input  wire logic                                  reset_n,
    // conversion tick and converted knob positions
    input  wire logic                                  sample,
    input  wire logic [kric_pkg::N_GEN-1:0][kric_pkg::KNOB_W-1:0] gen_pos,
    input  wire logic [kric_pkg::KNOB_W-1:0]           iris_pos,
    input  wire logic [kric_pkg::KNOB_W-1:0]           span_centre,
    input  wire logic [kric_pkg::KNOB_W-1:0]           span_width,
    // operator switches, high while pressed
    input  wire logic                                  release_sw,
    input  wire logic                                  relative_sw,
    input  wire logic                                  full_sw,
    // connection and configuration
    input  wire logic                                  panel_enable,
    input  wire logic                                  cam_link_up,
    input  wire logic [kric_pkg::ASSIGN_W-1:0]         cam_assign,
    input  wire logic                                  net_connected,
    input  wire logic                                  cfg_mode_set,
    input  wire logic                                  cfg_iris_rel,
    input  wire logic                                  cfg_blink_en,
    input  wire logic                                  cam_auto_iris,
    input  wire logic                                  cam_mismatch,
    // control data toward the camera
    output logic [kric_pkg::N_GEN-1:0][kric_pkg::DELTA_W-1:0] ctl_delta,
    output logic                                       ctl_valid,
    output logic [kric_pkg::DELTA_W-1:0]               iris_data,
    output logic                                       iris_abs,
    output logic                                       iris_clear,
    // lamps
    output logic                                       release_lamp,
    output logic                                       relative_lamp,
    output logic                                       full_lamp
);
    import kric_pkg::*;
    localparam int BW = $clog2(BLINK_CYC + 1);

    //******************************************************************
    // connection, switch edges and configuration
    //******************************************************************
    logic                connected_reg;   // link and enable both up
    logic                rel_sw_reg;      // switch history for edges
    logic                full_sw_reg;
    logic [ASSIGN_W-1:0] assign_reg;      // last camera assignment
    logic                full_reg;        // span knobs disabled
    logic                full_next;
    logic [BW-1:0]       blink_cnt_reg;   // blink half period
    logic                blink_reg;       // blink phase
    logic                rel_active;      // release switch state
    logic [KNOB_W-1:0]   abs_val_reg;     // absolute iris value sent
    wire                 connected   = panel_enable && cam_link_up;
    wire                 reconnect   = connected && !connected_reg;
    wire                 rel_press   = relative_sw && !rel_sw_reg;
    wire                 full_press  = full_sw && !full_sw_reg;
    wire                 assign_chg  = cam_assign != assign_reg;
    // explicit setting wins; otherwise network links run relative
    wire                 iris_rel    = cfg_mode_set ? cfg_iris_rel
                                                    : net_connected;
    wire                 file_clear  = (rel_press && iris_rel) || full_press;

    // edge history and connection state
    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            connected_reg <= 1'b0;
            rel_sw_reg    <= 1'b0;
            full_sw_reg   <= 1'b0;
            assign_reg    <= '0;
        end
        else
        begin
            connected_reg <= connected;
            rel_sw_reg    <= relative_sw;
            full_sw_reg   <= full_sw;
            assign_reg    <= cam_assign;
        end
    end

    // full state only changes on a press; enable toggling leaves it
    assign full_next = full_press ? !full_reg : full_reg;

    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
            full_reg <= FULL_RST;
        else
            full_reg <= full_next;
    end

    //******************************************************************
    // release switch
    //******************************************************************
    kric_release_ctl #(
        .LATCH_CYC   (LATCH_CYC)
    ) u_release (
        .mclk        (mclk),
        .reset_n     (reset_n),
        .sw          (release_sw),
        .clear_latch (assign_chg),
        .active      (rel_active),
        .lamp        (release_lamp)
    );

    //******************************************************************
    // general knobs: gain, pedestal, flare, knee, detail, gamma
    //******************************************************************
    // every channel is always covered by the release switch
    for (genvar k = 0; k < N_GEN; k++)
    begin : g_knob
        kric_knob_delta u_delta (
            .mclk     (mclk),
            .reset_n  (reset_n),
            .pos      (gen_pos[k]),
            .sample   (sample),
            .hold     (rel_active),
            .rebase   (reconnect),
            .zero_ref (1'b0),
            .delta    (ctl_delta[k])
        );
    end

    //******************************************************************
    // iris target: full range, span window or auto trim
    //******************************************************************
    // auto iris ignores the full switch and trims one stop each way
    wire                      use_win   = cam_auto_iris || !full_reg;
    wire [KNOB_W-1:0]         win_ctr   = cam_auto_iris ? IRIS_MID
                                                        : span_centre;
    wire [KNOB_W-1:0]         win_wid   = cam_auto_iris ? IRIS_FSTOP
                                                        : span_width;
    wire signed [KNOB_W:0]    knob_offs = $signed({1'b0, iris_pos})
                                        - $signed({1'b0, IRIS_MID});
    wire signed [2*KNOB_W+1:0] prod     = knob_offs
                                        * $signed({1'b0, win_wid});
    wire signed [KNOB_W+2:0]  scaled    = prod[2*KNOB_W+1:SCALE_SH];
    wire signed [KNOB_W+3:0]  win_sum   = $signed({4'b0000, win_ctr})
                                        + {scaled[KNOB_W+2], scaled};
    // clamp the window to the iris range at both ends
    wire [KNOB_W-1:0]         win_val   =
        win_sum[KNOB_W+3]        ? '0 :
        (win_sum[KNOB_W+2:KNOB_W] != 3'b000) ? IRIS_MAX :
        win_sum[KNOB_W-1:0];
    wire [KNOB_W-1:0]         iris_tgt  = use_win ? win_val
                                                  : iris_pos;
    wire [DELTA_W-1:0]        iris_delta;

    // iris is covered by the release switch only in relative mode
    kric_knob_delta u_iris (
        .mclk     (mclk),
        .reset_n  (reset_n),
        .pos      (iris_tgt),
        .sample   (sample),
        .hold     (rel_active && iris_rel),
        .rebase   (reconnect),
        .zero_ref (file_clear),
        .delta    (iris_delta)
    );

    //******************************************************************
    // outgoing data
    //******************************************************************
    // the clear pulse precedes the data that rebuilds the file; data
    // is only flagged while the link and enable are both up
    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            ctl_valid  <= 1'b0;
            iris_clear <= 1'b0;
            iris_abs    <= 1'b0;
            abs_val_reg <= '0;
        end
        else
        begin
            ctl_valid  <= sample && connected;
            iris_clear <= file_clear && connected;
            if (sample)
            begin
                iris_abs    <= !iris_rel;
                // absolute mode sends the iris target as is, jump accepted
                abs_val_reg <= iris_tgt;
            end
        end
    end

    // relative data is the iris channel's own registered change, so it
    // lines up with the general knobs instead of lagging one interval
    assign iris_data = iris_abs ? {1'b0, abs_val_reg}
                                : iris_delta;

    //******************************************************************
    // lamps
    //******************************************************************
    // blink timer free runs; cheaper than restarting on each mismatch
    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            blink_cnt_reg <= '0;
            blink_reg     <= 1'b0;
        end
        else if (blink_cnt_reg == BW'(BLINK_CYC - 1))
        begin
            blink_cnt_reg <= '0;
            blink_reg     <= !blink_reg;
        end
        else
        begin
            blink_cnt_reg <= blink_cnt_reg + 1'b1;
        end
    end

    wire blink_on = cam_mismatch && cfg_blink_en;

    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            relative_lamp <= 1'b0;
            full_lamp     <= FULL_RST;
        end
        else
        begin
            // dark in absolute mode, lit or blinking in relative
            relative_lamp <= iris_rel && (!blink_on || blink_reg);
            full_lamp     <= full_next;
        end
    end

    //******************************************************************
    // checks
    //******************************************************************
    chk_rel_lamp_lit: assert property (@(posedge mclk) disable iff (!reset_n)
        iris_rel && !blink_on ##1 iris_rel |-> relative_lamp)
        else $error("relative lamp dark in relative mode");
    chk_abs_lamp_dark: assert property (@(posedge mclk)
        disable iff (!reset_n)
        !iris_rel |=> !relative_lamp)
        else $error("relative lamp lit in absolute mode");
    chk_abs_iris_value: assert property (@(posedge mclk)
        disable iff (!reset_n)
        sample && !iris_rel
        |=> iris_abs && iris_data == {1'b0, $past(iris_tgt)})
        else $error("absolute iris value not sent");
    chk_full_ignore_span: assert property (@(posedge mclk)
        disable iff (!reset_n)
        full_reg && !cam_auto_iris |-> iris_tgt == iris_pos)
        else $error("span knobs used in full range");
    chk_full_toggle: assert property (@(posedge mclk) disable iff (!reset_n)
        full_press && connected
        |=> full_reg != $past(full_reg) && iris_clear)
        else $error("full press did not toggle and clear");
    chk_clear_first: assert property (@(posedge mclk) disable iff (!reset_n)
        rel_press && iris_rel && connected && !sample
        |=> iris_clear ##0 (u_iris.ref_reg == '0))
        else $error("relative press did not clear first");
    chk_auto_one_stop: assert property (@(posedge mclk)
        disable iff (!reset_n)
        cam_auto_iris && iris_pos == IRIS_MAX
        |-> iris_tgt <= IRIS_MID + IRIS_FSTOP)
        else $error("auto iris trim beyond one stop");
    chk_reconnect_quiet: assert property (@(posedge mclk)
        disable iff (!reset_n)
        reconnect && !rel_active |=> ctl_delta[0] == '0)
        else $error("knob jump sent on reconnection");
    chk_blink_off: assert property (@(posedge mclk) disable iff (!reset_n)
        iris_rel && !cfg_blink_en ##1 iris_rel |-> relative_lamp)
        else $error("lamp blinks with blinking disabled");
endmodule

//--- sim/kric_cam_model.sv
// camera side model: link state and a gain manual file
module kric_cam_model
(
    input  wire logic        mclk,
    input  wire logic        reset_n,
    input  wire logic        power_on,   // camera powered
    input  wire logic        ctl_valid,  // knob data strobe
    input  wire logic [10:0] gain_delta, // relative gain data
    output logic             cam_link_up,
    output logic      [10:0] gain_file   // accumulated gain data
);
    // the link is up only while the camera has power
    assign cam_link_up = power_on;
    // relative data adds into the file, so a jump would show here
    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
            gain_file <= 11'h000;
        else if (ctl_valid)
            gain_file <= gain_file + gain_delta;
    end
endmodule

//--- sim/kric_panel_ctl_tb_top.sv
// self-checking bench for the panel knob and iris control
module kric_panel_ctl_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import kric_pkg::*;
    localparam int LC = 20; // short latch window keeps the run brief
    logic mclk = 0, reset_n = 0, sample = 0, release_sw = 0;
    logic relative_sw = 0, full_sw = 0, panel_enable = 1, power_on = 1;
    logic net_connected = 1, cfg_mode_set = 0, cfg_iris_rel = 0;
    logic cfg_blink_en = 0, cam_auto_iris = 0, cam_mismatch = 0;
    logic [ASSIGN_W-1:0] cam_assign = 8'h00;
    logic [N_GEN-1:0][KNOB_W-1:0] gen_pos;
    logic [KNOB_W-1:0] iris_pos = 10'h12c;
    logic [KNOB_W-1:0] span_centre = 10'h200, span_width = 10'h200;
    logic [N_GEN-1:0][DELTA_W-1:0] ctl_delta;
    logic [DELTA_W-1:0] iris_data, gain_file;
    logic ctl_valid, iris_abs, iris_clear, cam_link_up;
    logic release_lamp, relative_lamp, full_lamp;
    int err_total = 0, n_tests = 0;
    // free running clock, 8 ns period
    always #4 mclk = ~mclk;
    kric_panel_ctl #(.LATCH_CYC(LC), .BLINK_CYC(4)) dut (.mclk, .reset_n,
        .sample, .gen_pos, .iris_pos, .span_centre, .span_width,
        .release_sw, .relative_sw, .full_sw, .panel_enable, .cam_link_up,
        .cam_assign, .net_connected, .cfg_mode_set, .cfg_iris_rel,
        .cfg_blink_en, .cam_auto_iris, .cam_mismatch, .ctl_delta,
        .ctl_valid, .iris_data, .iris_abs, .iris_clear, .release_lamp,
        .relative_lamp, .full_lamp);
    kric_cam_model cam (.mclk, .reset_n, .power_on, .ctl_valid,
        .gain_delta(ctl_delta[0]), .cam_link_up, .gain_file);
    //**************************************************************
    // shared tasks
    //**************************************************************
    // inputs always move 1 ns after the rising edge
    task automatic tick(int n = 1);
        repeat (n) @(posedge mclk);
        #1;
    endtask
    task automatic chk(string nm, logic [15:0] seen, logic [15:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            err_total++;
            $display("[ERR] %s exp %h seen %h", nm, exp, seen);
        end
    endtask
    // one conversion tick; answers are registered on that edge
    task automatic smp();
        sample = 1;
        tick();
        sample = 0;
    endtask
    task automatic give_verdict();
        $display("checks %0d errors %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    //**************************************************************
    // scenarios
    //**************************************************************
    // knob change only, then panel toggle and camera power cycle
    task automatic t_delta();
        gen_pos[0] = 10'h082;
        smp();
        chk("valid", ctl_valid, 16'h0001);
        chk("delta", ctl_delta[0], 16'h001e);
        for (int i = 0; i < 2; i++)
        begin
            {panel_enable, power_on} = i ? 2'b10 : 2'b01;
            tick(2);
            gen_pos[0] += 10'h064;
            smp();
            chk("idle valid", ctl_valid, 16'h0000);
            {panel_enable, power_on} = 2'b11;
            tick(2);
            smp();
            chk("reconn delta", ctl_delta[0], 16'h0000);
        end
        chk("cam file", gain_file, 16'h001e);
    endtask
    // long hold freezes knobs, let go rebases without a lock
    task automatic t_hold();
        release_sw = 1;
        tick(2);
        gen_pos[0] = 10'h190;
        iris_pos = 10'h15e;
        smp();
        chk("held delta", ctl_delta[0], 16'h0000);
        chk("held iris", iris_data, 16'h0000);
        tick(LC + 5);
        release_sw = 0;
        tick(2);
        chk("no lock", release_lamp, 16'h0000);
        smp();
        chk("rebase", ctl_delta[0], 16'h0000);
        gen_pos[0] = 10'h19a;
        smp();
        chk("resume", ctl_delta[0], 16'h000a);
    endtask
    // short press locks; cleared by a second press, then reassignment
    task automatic t_lock();
        for (int i = 0; i < 2; i++)
        begin
            release_sw = 1;
            tick(3);
            release_sw = 0;
            tick(2);
            chk("lock lamp", release_lamp, 16'h0001);
            gen_pos[0] += 10'h005;
            smp();
            chk("lock delta", ctl_delta[0], 16'h0000);
            release_sw = (i == 0);
            cam_assign += 8'(i);
            tick(3);
            release_sw = 0;
            tick(2);
            chk("unlock lamp", release_lamp, 16'h0000);
            gen_pos[0] += 10'h007;
            smp();
            chk("unlock delta", ctl_delta[0], 16'h0007);
        end
    endtask
    // relative press: clear command first, then the whole target
    task automatic t_rel();
        chk("rel lamp", relative_lamp, 16'h0001);
        iris_pos = 10'h12c;
        relative_sw = 1;
        tick();
        relative_sw = 0;
        chk("clear", iris_clear, 16'h0001);
        tick();
        chk("clear end", iris_clear, 16'h0000);
        smp();
        chk("rel abs", iris_abs, 16'h0000);
        chk("rel iris", iris_data, 16'h012c);
    endtask
    // absolute mode: window, full range, auto iris, reconnect value
    task automatic t_abs();
        {cfg_mode_set, cfg_iris_rel} = 2'b10;
        {span_centre, span_width, iris_pos} = {10'h100, 10'h100, 10'h300};
        tick(2);
        chk("abs lamp", relative_lamp, 16'h0000);
        smp();
        chk("abs flag", iris_abs, 16'h0001);
        chk("window", iris_data, 16'h0180);
        full_sw = 1;
        tick();
        full_sw = 0;
        chk("full clear", iris_clear, 16'h0001);
        chk("full lamp", full_lamp, 16'h0001);
        {span_centre, span_width} = 20'h0_0000;
        smp();
        chk("full iris", iris_data, 16'h0300);
        {cam_auto_iris, iris_pos} = {1'b1, 10'h3ff};
        smp();
        chk("auto iris", iris_data, 16'h027f);
        {cam_auto_iris, panel_enable} = 2'b00;
        tick(2);
        panel_enable = 1;
        tick(2);
        chk("full kept", full_lamp, 16'h0001);
        smp();
        chk("abs jump", iris_data, 16'h03ff);
        cfg_mode_set = 0;
    endtask
    // mismatch blinks the relative lamp unless blinking is disabled
    task automatic t_blink();
        int lo;
        for (int en = 1; en >= 0; en--)
        begin
            {cam_mismatch, cfg_blink_en, lo} = {1'b1, en[0], 32'h0};
            tick(2);
            repeat (12)
            begin
                tick();
                lo += int'(relative_lamp !== 1'b1);
            end
            chk("blink", 16'(lo != 0), 16'(en));
        end
    endtask
    //**************************************************************
    // main sequence and watchdog
    //**************************************************************
    initial
    begin
        gen_pos = '0;
        gen_pos[0] = 10'h064;
        repeat (2) @(posedge mclk);
        #1;
        reset_n = 1;
        tick(3);
        t_delta();
        t_hold();
        t_lock();
        t_rel();
        t_abs();
        t_blink();
        give_verdict();
    end
    // the tests need well under 500 cycles
    initial
    begin
        #20000;
        err_total++;
        give_verdict();
    end
endmodule
